// ### verilog/lau_pkg.sv
// Constants and types for the logical AND instruction unit.
// Assumes the core supplies opcode bytes and operand values on clk_i.
package lau_pkg;

  // ==========================================================
  // Opcode patterns
  localparam logic [7:0] OPC_AND_IMM  = 8'h54;
  localparam logic [7:0] OPC_AND_DIR  = 8'h55;
  localparam logic [6:0] OPC_AND_IND  = 7'h2b;  // Upper seven bits, low bit picks pointer
  localparam logic [4:0] OPC_AND_REG  = 5'h0b;  // Upper five bits, low three pick register
  localparam logic [7:0] OPC_AND_BIT  = 8'h82;
  localparam logic [7:0] OPC_AND_NBIT = 8'hb0;

  // ==========================================================
  // Timing: one state per clock, six states per machine cycle
  localparam int unsigned   STATES_PER_CYCLE = 6;
  localparam int unsigned   BYTE_CYCLES      = 1;
  localparam int unsigned   BIT_CYCLES       = 2;
  localparam logic [3:0]    BYTE_LAST_STATE  = 4'(STATES_PER_CYCLE * BYTE_CYCLES - 1);
  localparam logic [3:0]    BIT_LAST_STATE   = 4'(STATES_PER_CYCLE * BIT_CYCLES - 1);
  localparam logic [3:0]    STATE_ZERO       = 4'h0;
  localparam logic [3:0]    STATE_STEP       = 4'h1;
  localparam logic [7:0]    BYTE_ZERO        = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LAU_FORM_NONE = 3'h0,
    LAU_FORM_IMM  = 3'h1,
    LAU_FORM_DIR  = 3'h2,
    LAU_FORM_IND  = 3'h3,
    LAU_FORM_REG  = 3'h4,
    LAU_FORM_BIT  = 3'h5,
    LAU_FORM_NBIT = 3'h6
  } lau_form_t;

  typedef enum logic [2:0] {
    LAU_SPACE_NONE    = 3'h0,
    LAU_SPACE_DIRECT  = 3'h1,
    LAU_SPACE_POINTER = 3'h2,
    LAU_SPACE_WORKING = 3'h3,
    LAU_SPACE_BIT     = 3'h4
  } lau_space_t;

  // Gray along idle -> run -> done
  typedef enum logic [1:0] {
    LAU_ST_IDLE = 2'b00,
    LAU_ST_RUN  = 2'b01,
    LAU_ST_DONE = 2'b11
  } lau_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;  // Second instruction byte, ignored by one-byte forms
  } lau_instr_t;

  typedef struct packed {
    lau_space_t space;
    logic [7:0] addr;
  } lau_fetch_t;

  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc;
    logic       carry_we;
    logic       carry;
  } lau_wb_t;

  localparam lau_fetch_t FETCH_IDLE = '{space: LAU_SPACE_NONE, addr: 8'h00};
  localparam lau_wb_t    WB_IDLE    = '{acc_we: 1'b0, acc: 8'h00, carry_we: 1'b0, carry: 1'b0};

  function automatic lau_form_t lau_decode(input logic [7:0] opc);
    lau_form_t f;
    f = LAU_FORM_NONE;
    if (opc == OPC_AND_IMM) begin
      f = LAU_FORM_IMM;
    end else if (opc == OPC_AND_DIR) begin
      f = LAU_FORM_DIR;
    end else if (opc[7:1] == OPC_AND_IND) begin
      f = LAU_FORM_IND;
    end else if (opc[7:3] == OPC_AND_REG) begin
      f = LAU_FORM_REG;
    end else if (opc == OPC_AND_BIT) begin
      f = LAU_FORM_BIT;
    end else if (opc == OPC_AND_NBIT) begin
      f = LAU_FORM_NBIT;
    end
    return f;
  endfunction

  function automatic logic lau_is_bit_form(input lau_form_t f);
    return (f == LAU_FORM_BIT) || (f == LAU_FORM_NBIT);
  endfunction

endpackage

// ### verilog/lau_alu.sv
// Combinational AND datapath for byte and carry forms.
// Assumes operands are stable during the last state of execution.
module lau_alu (
  // Selected form
  input  wire lau_pkg::lau_form_t form_i,
  // Operands
  input  wire logic [7:0]         acc_i,
  input  wire logic [7:0]         src_byte_i,
  input  wire logic               src_bit_i,
  input  wire logic               carry_i,
  // Results
  output logic [7:0]              acc_o,
  output logic                    carry_o
);

  logic src_val;

  always_comb begin
    acc_o   = acc_i & src_byte_i;
    // Complement only feeds the AND; the addressed bit is never written
    src_val = (form_i == lau_pkg::LAU_FORM_NBIT) ? ~src_bit_i : src_bit_i;
    // Zero source clears carry, one leaves it as it was
    carry_o = src_val ? carry_i : 1'b0;
  end

endmodule

// ### verilog/lau_unit.sv
// Logical AND instruction unit: decode, operand fetch and write-back.
// Assumes the core issues one opcode while accept_o is high and answers
// fetch_o with src_byte_i/src_bit_i before the last state of the instruction.
//
// Operation
// - Opcode 0101 0100 plus immediate byte: accumulator ANDed with constant, one cycle.
// - Direct form: accumulator ANDed with directly addressed byte, two bytes, one cycle.
// - Opcode 0101 011i: accumulator ANDed with RAM byte at pointer i, one cycle.
// - Carry AND: zero source bit clears carry, one leaves carry unchanged.
// - Complemented carry AND uses inverted bit and never writes the bit.
// - Carry AND with bit address: two bytes, twelve states, two cycles.
module lau_unit (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // Instruction issue
  input  wire logic                issue_i,
  input  wire lau_pkg::lau_instr_t instr_i,
  output logic                     accept_o,
  output logic                     busy_o,
  output logic                     unknown_o,
  // Operand fetch
  output lau_pkg::lau_fetch_t      fetch_o,
  input  wire logic [7:0]          acc_i,
  input  wire logic [7:0]          src_byte_i,
  input  wire logic                src_bit_i,
  input  wire logic                carry_i,
  // Write-back
  output lau_pkg::lau_wb_t         wb_o,
  output logic                     done_o
);

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  // ==========================================================
  // Sequencer state
  lau_pkg::lau_state_t state;
  lau_pkg::lau_state_t next_state;
  lau_pkg::lau_form_t  form;
  lau_pkg::lau_form_t  next_form;
  lau_pkg::lau_fetch_t next_fetch;
  lau_pkg::lau_wb_t    next_wb;
  logic [7:0]          imm;
  logic [7:0]          next_imm;
  logic [3:0]          states_left;
  logic [3:0]          next_states_left;
  logic                next_done;
  logic                next_unknown;
  logic [7:0]          alu_acc;
  logic                alu_carry;
  logic [7:0]          src_byte;
  lau_pkg::lau_form_t  issue_form;
  lau_pkg::lau_fetch_t issue_fetch;
  logic [3:0]          issue_last;
  logic                issue_known;

  assign accept_o   = (state == lau_pkg::LAU_ST_IDLE);
  assign busy_o     = !accept_o;
  assign issue_form = lau_pkg::lau_decode(instr_i.opcode);
  // Immediate data travels in the instruction, not over the fetch port
  assign src_byte   = (form == lau_pkg::LAU_FORM_IMM) ? imm : src_byte_i;

  lau_alu u_alu (
    .form_i     (form),
    .acc_i      (acc_i),
    .src_byte_i (src_byte),
    .src_bit_i  (src_bit_i),
    .carry_i    (carry_i),
    .acc_o      (alu_acc),
    .carry_o    (alu_carry)
  );

  // ==========================================================
  // Issue decode
  // Evaluated every cycle, used only on the edge that takes an issue
  always_comb begin
    issue_fetch = lau_pkg::FETCH_IDLE;
    issue_last  = lau_pkg::STATE_ZERO;
    issue_known = 1'b1;
    case (issue_form)
      lau_pkg::LAU_FORM_IMM: begin
        issue_last = lau_pkg::BYTE_LAST_STATE;
      end
      lau_pkg::LAU_FORM_DIR: begin
        issue_fetch.space = lau_pkg::LAU_SPACE_DIRECT;
        issue_fetch.addr  = instr_i.operand;
        issue_last        = lau_pkg::BYTE_LAST_STATE;
      end
      lau_pkg::LAU_FORM_IND: begin
        // Core resolves the pointer and returns the RAM byte on src_byte_i
        issue_fetch.space = lau_pkg::LAU_SPACE_POINTER;
        issue_fetch.addr  = {7'h00, instr_i.opcode[0]};
        issue_last        = lau_pkg::BYTE_LAST_STATE;
      end
      lau_pkg::LAU_FORM_REG: begin
        issue_fetch.space = lau_pkg::LAU_SPACE_WORKING;
        issue_fetch.addr  = {5'h00, instr_i.opcode[2:0]};
        issue_last        = lau_pkg::BYTE_LAST_STATE;
      end
      lau_pkg::LAU_FORM_BIT,
      lau_pkg::LAU_FORM_NBIT: begin
        // Second byte is the bit address
        issue_fetch.space = lau_pkg::LAU_SPACE_BIT;
        issue_fetch.addr  = instr_i.operand;
        issue_last        = lau_pkg::BIT_LAST_STATE;
      end
      default: begin
        // Not ours: refused in one cycle, no write-back
        issue_known = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Instruction sequencer
  always_comb begin
    next_state       = state;
    next_form        = form;
    next_imm         = imm;
    next_states_left = states_left;
    case (state)
      lau_pkg::LAU_ST_IDLE: begin
        if (issue_i && issue_known) begin
          next_form        = issue_form;
          next_imm         = instr_i.operand;
          next_states_left = issue_last;
          next_state       = lau_pkg::LAU_ST_RUN;
        end
      end
      lau_pkg::LAU_ST_RUN: begin
        if (states_left == lau_pkg::STATE_ZERO) begin
          next_state = lau_pkg::LAU_ST_DONE;
        end else begin
          next_states_left = states_left - lau_pkg::STATE_STEP;
        end
      end
      lau_pkg::LAU_ST_DONE: begin
        // One idle cycle lets the core's accumulator/carry settle before reuse
        next_state = lau_pkg::LAU_ST_IDLE;
        next_form  = lau_pkg::LAU_FORM_NONE;
      end
      default: begin
        next_state = lau_pkg::LAU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state       <= lau_pkg::LAU_ST_IDLE;
      form        <= lau_pkg::LAU_FORM_NONE;
      imm         <= lau_pkg::BYTE_ZERO;
      states_left <= lau_pkg::STATE_ZERO;
    end else begin
      state       <= next_state;
      form        <= next_form;
      imm         <= next_imm;
      states_left <= next_states_left;
    end
  end

  // ==========================================================
  // Port registers
  always_comb begin
    next_fetch   = fetch_o;
    next_wb      = lau_pkg::WB_IDLE;
    next_done    = 1'b0;
    next_unknown = 1'b0;
    case (state)
      lau_pkg::LAU_ST_IDLE: begin
        if (issue_i) begin
          next_fetch   = issue_fetch;
          next_unknown = !issue_known;
        end
      end
      lau_pkg::LAU_ST_RUN: begin
        if (states_left == lau_pkg::STATE_ZERO) begin
          if (lau_pkg::lau_is_bit_form(form)) begin
            // Only the carry is written; the source bit has no write path
            next_wb.carry_we = 1'b1;
            next_wb.carry    = alu_carry;
          end else begin
            // Accumulator only; flags keep their values
            next_wb.acc_we = 1'b1;
            next_wb.acc    = alu_acc;
          end
          next_done  = 1'b1;
          next_fetch = lau_pkg::FETCH_IDLE;
        end
      end
      default: begin
        next_fetch = lau_pkg::FETCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      fetch_o   <= lau_pkg::FETCH_IDLE;
      wb_o      <= lau_pkg::WB_IDLE;
      done_o    <= 1'b0;
      unknown_o <= 1'b0;
    end else begin
      fetch_o   <= next_fetch;
      wb_o      <= next_wb;
      done_o    <= next_done;
      unknown_o <= next_unknown;
    end
  end

endmodule

// ### tb/lau_checker.sv
// Port checker for the AND instruction unit.
// Assumes a bind onto lau_unit; raw reset disables all checks.
module lau_checker (
  // Clock and reset
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  // Issue
  input wire logic                issue_i,
  input wire lau_pkg::lau_instr_t instr_i,
  input wire logic                accept_o,
  // Operands and results
  input wire lau_pkg::lau_fetch_t fetch_o,
  input wire logic [7:0]          acc_i,
  input wire logic                src_bit_i,
  input wire logic                carry_i,
  input wire lau_pkg::lau_wb_t    wb_o,
  input wire logic                done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Taken requests
  logic bf;
  logic bt;
  logic bb;
  assign bf = instr_i.opcode == lau_pkg::OPC_AND_BIT || instr_i.opcode == lau_pkg::OPC_AND_NBIT;
  assign bt = issue_i && accept_o && instr_i.opcode[7:4] == 4'h5 && instr_i.opcode[3:2] != 2'h0;
  assign bb = issue_i && accept_o && bf;
  sequence s_byte_wait; ##1 !done_o [*6] ##1 done_o; endsequence
  sequence s_bit_wait; ##1 !done_o [*6] ##1 !done_o [*6] ##1 done_o; endsequence
  property p_imm;
    logic [7:0] d;
    (bt && instr_i.opcode == lau_pkg::OPC_AND_IMM, d = instr_i.operand) |->
      ##7 wb_o.acc_we && wb_o.acc == ($past(acc_i) & d);
  endproperty
  // ==========================================================
  // Assertions
  a_byte_latency: assert property (bt |-> s_byte_wait) else $error("byte form latency wrong");
  a_bit_latency: assert property (bb |-> s_bit_wait) else $error("bit form latency wrong");
  a_imm_result: assert property (p_imm) else $error("immediate result wrong");
  a_byte_flags: assert property (wb_o.acc_we |-> !wb_o.carry_we) else $error("byte form wrote carry");
  a_bit_carry: assert property (bb && !instr_i.opcode[5] |-> ##13 wb_o.carry_we && wb_o.carry ==
    ($past(carry_i) & $past(src_bit_i))) else $error("carry result wrong");
  a_nbit_carry: assert property (bb && instr_i.opcode[5] |-> ##13 wb_o.carry_we && !wb_o.acc_we &&
    wb_o.carry == ($past(carry_i) & ~$past(src_bit_i))) else $error("inverted carry wrong");
  a_dir_fetch: assert property (bt && instr_i.opcode == lau_pkg::OPC_AND_DIR |-> ##1 fetch_o.space ==
    lau_pkg::LAU_SPACE_DIRECT && fetch_o.addr == $past(instr_i.operand)) else $error("direct fetch wrong");
  a_ind_fetch: assert property (bt && instr_i.opcode[7:1] == lau_pkg::OPC_AND_IND |-> ##1 fetch_o.space ==
    lau_pkg::LAU_SPACE_POINTER && fetch_o.addr == {7'h00, $past(instr_i.opcode[0])}) else $error("pointer wrong");
  a_reg_fetch: assert property (bt && instr_i.opcode[7:3] == lau_pkg::OPC_AND_REG |-> ##1 fetch_o.space ==
    lau_pkg::LAU_SPACE_WORKING && fetch_o.addr == {5'h00, $past(instr_i.opcode[2:0])}) else $error("reg wrong");
endmodule

bind lau_unit lau_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .issue_i(issue_i), .instr_i(instr_i),
  .accept_o(accept_o), .fetch_o(fetch_o), .acc_i(acc_i), .src_bit_i(src_bit_i), .carry_i(carry_i),
  .wb_o(wb_o), .done_o(done_o));

// ### tb/tb.sv
// Self-checking bench for the AND instruction unit.
// Assumes lau_pkg and lau_unit are compiled first; inputs move on falling edges.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic                issue_i = 1'b0;
  logic                src_bit_i = 1'b0;
  logic                carry_i = 1'b0;
  logic [7:0]          acc_i = 8'h00;
  logic [7:0]          src_byte_i = 8'h00;
  lau_pkg::lau_instr_t instr_i = '0;
  logic                accept_o;
  logic                busy_o;
  logic                unknown_o;
  logic                done_o;
  lau_pkg::lau_fetch_t fetch_o;
  lau_pkg::lau_wb_t    wb_o;
  int                  num_errors = 0;
  int                  num_checks = 0;
  lau_unit dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .issue_i(issue_i), .instr_i(instr_i), .accept_o(accept_o),
    .busy_o(busy_o), .unknown_o(unknown_o), .fetch_o(fetch_o), .acc_i(acc_i), .src_byte_i(src_byte_i),
    .src_bit_i(src_bit_i), .carry_i(carry_i), .wb_o(wb_o), .done_o(done_o));
  initial forever #4 clk_i = ~clk_i;
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Byte forms hide the carry value, bit forms the accumulator field
  task automatic run(input logic [15:0] ins, input int lat, input logic [10:0] ftc, input logic [10:0] res);
    int n;
    n = 1;
    chk(11'(accept_o), 11'h001);
    issue_i = 1'b1;
    instr_i = ins;
    @(negedge clk_i);
    issue_i = 1'b0;
    chk(11'({busy_o, accept_o}), 11'h002);
    chk(fetch_o, ftc);
    while (done_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    chk(11'(n), 11'(lat));
    chk(wb_o & (lat == 13 ? 11'h403 : 11'h7fe), res);
    repeat (2) @(negedge clk_i);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_imm();
    acc_i = 8'hc3;
    run(16'h5455, 7, 11'h000, {1'b1, 8'h41, 2'h0});
    acc_i = 8'hff;
    run(16'h5400, 7, 11'h000, {1'b1, 8'h00, 2'h0});
    $display("immediate test done");
  endtask
  task automatic t_dir();
    acc_i = 8'hf3;
    src_byte_i = 8'h0f;
    carry_i = 1'b1;
    run(16'h557f, 7, {3'h1, 8'h7f}, {1'b1, 8'h03, 2'h0});
    $display("direct test done");
  endtask
  task automatic t_ind();
    for (int i = 0; i < 2; i++) begin
      acc_i = 8'h9e;
      src_byte_i = 8'h5a ^ 8'(i);
      run({7'h2b, 1'(i), 8'hee}, 7, {3'h2, 8'(i)}, {1'b1, 8'h9e & src_byte_i, 2'h0});
    end
    $display("indirect test done");
  endtask
  task automatic t_reg();
    for (int r = 0; r < 8; r++) begin
      acc_i = 8'he7;
      src_byte_i = 8'h3c + 8'(r);
      run({5'h0b, 3'(r), 8'h00}, 7, {3'h3, 8'(r)}, {1'b1, 8'he7 & src_byte_i, 2'h0});
    end
    $display("register test done");
  endtask
  task automatic t_bit();
    logic [2:0] k;
    for (int j = 0; j < 8; j++) begin
      k = 3'(j);
      src_bit_i = k[0];
      carry_i = k[1];
      run({k[2] ? 8'hb0 : 8'h82, 8'h20 + 8'(j)}, 13, {3'h4, 8'h20 + 8'(j)},
        {9'h001, k[1] & (k[0] ^ k[2])});
    end
    $display("carry test done");
  endtask
  // Unknown opcode answers with a pulse and stays idle; issue while busy is ignored
  task automatic t_unk();
    issue_i = 1'b1;
    instr_i = 16'h5233;
    @(negedge clk_i);
    issue_i = 1'b0;
    chk(11'({unknown_o, accept_o, done_o, wb_o.acc_we}), 11'h00c);
    @(negedge clk_i);
    chk(11'({unknown_o, accept_o, fetch_o.space}), 11'h008);
    acc_i = 8'hff;
    src_byte_i = 8'h3c;
    issue_i = 1'b1;
    instr_i = 16'h55a5;
    @(negedge clk_i);
    instr_i = 16'h8277;
    chk(fetch_o, {3'h1, 8'ha5});
    repeat (4) @(negedge clk_i);
    issue_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk(11'(done_o), 11'h001);
    chk(wb_o, {1'b1, 8'h3c, 2'h0});
    repeat (2) @(negedge clk_i);
    $display("refusal test done");
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (5) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_imm();
    t_dir();
    t_ind();
    t_reg();
    t_bit();
    t_unk();
    close_out();
  end
  initial begin
    #20000;
    num_errors++;
    close_out();
  end
endmodule
